/* logic/capture_ctrl_pkg.sv */
// Purpose: constants and carrier types for the three-channel capture control block
// Assumes: AXI4-Lite, 32-bit data, 100 MHz aclk
// Notes:   register offsets are byte addresses (printed index times four)
package capture_ctrl_pkg;

  localparam int          num_channels      = 3;
  localparam int          addr_width        = 12;
  // printed register indices
  localparam logic [7:0]  enable_flags_index = 8'h92;
  localparam logic [7:0]  edge_select_index  = 8'h93;
  localparam logic [7:0]  filter_index       = 8'h94;
  // own registers for interrupt status and mask
  localparam logic [7:0]  irq_status_index   = 8'h98;
  localparam logic [7:0]  irq_mask_index     = 8'h99;
  localparam logic [7:0]  reg_reset          = 8'h00;
  // field positions
  localparam int          flag_lsb          = 0;
  localparam int          enable_lsb        = 4;
  localparam int          filter_lsb        = 4;
  localparam int          edge_field_width  = 2;
  // edge select encodings
  localparam logic [1:0]  edge_falling      = 2'h0;
  localparam logic [1:0]  edge_rising       = 2'h1;
  localparam logic [1:0]  edge_either       = 2'h2;
  // noise filter: input must stand stable this long before it is accepted
  localparam int          filter_time_ns    = 40;
  localparam int          clk_period_ns     = 10;
  localparam int          filter_cycles     = (filter_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int          filter_cnt_width  = 3;
  localparam logic [1:0]  resp_okay         = 2'h0;
  localparam logic [1:0]  resp_slverr       = 2'h2;
  localparam logic [31:0] read_zero         = 32'h0000_0000;

  typedef struct packed {
    logic [2:0]                  sync1;
    logic [2:0]                  sync2;
    logic [2:0]                  filtered;
    logic [2:0]                  last_level;
    logic [2:0][filter_cnt_width-1:0] stable_cnt;
  } channel_state_t;

  typedef struct packed {
    logic [7:0]  enable_flags;
    logic [7:0]  edge_select;
    logic [7:0]  filter_enable;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic        aw_held;
    logic [addr_width-1:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    channel_state_t ch;
  } ctrl_state_t;

endpackage

/* logic/three_channel_input_capture_ctrl.sv */
// Purpose: enable, edge select, noise filter and event flags of three capture inputs
// Assumes: capture pins are asynchronous; one AXI4-Lite master
// Notes:   interrupt line high while an unmasked status bit is set
//
// Overview of operation
// RQ1: enable bits 4, 5, 6 of the first register; channel acts only when set.
// RQ2: hardware sets flag bits 0..2 of the first register on the selected edge.
// RQ3: software clears each flag by writing zero; hardware never clears it.
// RQ4: two-bit edge select per channel: 00 falling, 01 rising, 10 either.
// RQ5: software must not program the reserved edge select value 11.
// RQ6: filter enable bits 4..6 route a channel through a noise filter first.
// RQ7: a disabled channel ignores edges and keeps its flag unchanged.
`timescale 1ns/1ps
module three_channel_input_capture_ctrl
  import capture_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // capture pins
  input  wire logic [2:0]            capture_in,
  // axi4-lite write address
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [addr_width-1:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // axi4-lite write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // axi4-lite read address
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [addr_width-1:0] s_axi_araddr,
  // axi4-lite read data
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // interrupt
  output logic                       capture_irq
);

  ctrl_state_t state;
  ctrl_state_t next_state;

  function automatic logic [addr_width-1:0] byte_addr(input logic [7:0] index);
    byte_addr = addr_width'({index, 2'b00});
  endfunction

  function automatic logic reg_hit(input logic [addr_width-1:0] addr, input logic [7:0] index);
    reg_hit = (addr == byte_addr(index));
  endfunction

  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] hit;
  logic [2:0] sel_level;
  logic       wr_go;
  logic       rd_go;

  assign s_axi_awready = !state.aw_held && !state.bvalid;
  assign s_axi_wready  = !state.w_held && !state.bvalid;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;
  assign capture_irq   = |(state.irq_status & state.irq_mask);

  always_comb
  begin
    logic [2:0]  new_hits;
    logic [7:0]  wbyte;
    logic        wr_hit_ok;
    logic [addr_width-1:0] waddr;
    logic        aw_have;
    logic        w_have;
    new_hits   = 3'b000;
    wbyte      = 8'h00;
    wr_hit_ok  = 1'b0;
    next_state = state;
    aw_have    = state.aw_held || s_axi_awvalid;
    w_have     = state.w_held || s_axi_wvalid;
    waddr      = state.aw_held ? state.aw_addr : s_axi_awaddr;
    wr_go      = aw_have && w_have && !state.bvalid;
    rd_go      = s_axi_arvalid && !state.rvalid;

    // pins pass two flip-flops before anything reads them
    next_state.ch.sync1 = capture_in;
    next_state.ch.sync2 = state.ch.sync1;
    for (int i = 0; i < num_channels; i++)
    begin
      // noise filter: level accepted only after it stands stable
      if (state.ch.sync2[i] == state.ch.filtered[i])
        next_state.ch.stable_cnt[i] = '0;
      else if (state.ch.stable_cnt[i] == filter_cnt_width'(filter_cycles - 1))
      begin
        next_state.ch.filtered[i]   = state.ch.sync2[i];
        next_state.ch.stable_cnt[i] = '0;
      end
      else
        next_state.ch.stable_cnt[i] = state.ch.stable_cnt[i] + 1'b1;
      // RQ6 filter path select
      sel_level[i] = state.filter_enable[filter_lsb + i] ? state.ch.filtered[i]
                                                         : state.ch.sync2[i];
      next_state.ch.last_level[i] = sel_level[i];
      rise[i] = sel_level[i] && !state.ch.last_level[i];
      fall[i] = !sel_level[i] && state.ch.last_level[i];
      // RQ4 edge decode; reserved 11 never triggers
      case (state.edge_select[edge_field_width*i +: edge_field_width])
        edge_falling: hit[i] = fall[i];
        edge_rising:  hit[i] = rise[i];
        edge_either:  hit[i] = rise[i] || fall[i];
        default:      hit[i] = 1'b0;
      endcase
      // RQ1 RQ7 gate by channel enable
      new_hits[i] = hit[i] && state.enable_flags[enable_lsb + i];
    end

    // write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (wr_go)
    begin
      wbyte = state.w_held ? state.w_data[7:0] : s_axi_wdata[7:0];
      wr_hit_ok = state.w_held ? state.w_strb[0] : s_axi_wstrb[0];
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = resp_okay;
      if (reg_hit(waddr, enable_flags_index))
      begin
        // RQ3 software writes flags, zero clears
        if (wr_hit_ok)
          next_state.enable_flags = wbyte & 8'h77;
      end
      else if (reg_hit(waddr, edge_select_index))
      begin
        if (wr_hit_ok)
          next_state.edge_select = wbyte & 8'h3F;
      end
      else if (reg_hit(waddr, filter_index))
      begin
        if (wr_hit_ok)
          next_state.filter_enable = wbyte & 8'h70;
      end
      else if (reg_hit(waddr, irq_mask_index))
      begin
        if (wr_hit_ok)
          next_state.irq_mask = wbyte[2:0];
      end
      else if (!reg_hit(waddr, irq_status_index))
        next_state.bresp = resp_slverr;
    end
    if (state.bvalid && s_axi_bready)
      next_state.bvalid = 1'b0;

    // read channel; status read clears its sticky bits
    if (rd_go)
    begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = resp_okay;
      next_state.rdata  = read_zero;
      if (reg_hit(s_axi_araddr, enable_flags_index))
        next_state.rdata[7:0] = state.enable_flags;
      else if (reg_hit(s_axi_araddr, edge_select_index))
        next_state.rdata[7:0] = state.edge_select;
      else if (reg_hit(s_axi_araddr, filter_index))
        next_state.rdata[7:0] = state.filter_enable;
      else if (reg_hit(s_axi_araddr, irq_mask_index))
        next_state.rdata[2:0] = state.irq_mask;
      else if (reg_hit(s_axi_araddr, irq_status_index))
      begin
        next_state.rdata[2:0] = state.irq_status;
        next_state.irq_status = 3'b000;
      end
      else
        next_state.rresp = resp_slverr;
    end
    if (state.rvalid && s_axi_rready)
      next_state.rvalid = 1'b0;

    // RQ2 set wins over software clear
    next_state.enable_flags[flag_lsb +: num_channels] =
      next_state.enable_flags[flag_lsb +: num_channels] | new_hits;
    next_state.irq_status = next_state.irq_status | new_hits;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state               <= '0;
      state.enable_flags  <= reg_reset;
      state.edge_select   <= reg_reset;
      state.filter_enable <= reg_reset;
    end
    else
      state <= next_state;
  end

endmodule

/* testbench/capture_ctrl_monitor.sv */
// Purpose: port-level checks of the capture control block
// Assumes: one clock, synchronous active-low reset
// Notes:   mapped byte addresses are index times four
`timescale 1ns/1ps
module capture_ctrl_monitor
  import capture_ctrl_pkg::*;
(
  input wire logic        aclk, aresetn, capture_irq,
  input wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    !capture_irq && !s_axi_bvalid && !s_axi_rvalid && s_axi_awready) else $error("reset state");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pends");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
  a_resp_release: assert property ((s_axi_bvalid && s_axi_bready) or
    (s_axi_rvalid && s_axi_rready) |=> !(s_axi_bvalid && s_axi_rvalid)) else $error("no release");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
    !(s_axi_araddr inside {12'h248, 12'h24C, 12'h250, 12'h260, 12'h264}) |=>
    s_axi_rresp == resp_slverr && s_axi_rdata == read_zero) else $error("unmapped read");
endmodule
bind three_channel_input_capture_ctrl capture_ctrl_monitor mon (
  .aclk          (aclk),
  .aresetn       (aresetn),
  .capture_irq   (capture_irq),
  .s_axi_awready (s_axi_awready),
  .s_axi_wready  (s_axi_wready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_araddr  (s_axi_araddr),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_rresp   (s_axi_rresp),
  .s_axi_rdata   (s_axi_rdata)
);

/* testbench/capture_pins_model.sv */
// Purpose: external signals on the three capture pins
// Assumes: pins are levels that hold between changes
// Notes:   changes land right after a rising edge
`timescale 1ns/1ps
module capture_pins_model (
  // clock
  input  wire logic       aclk,
  // pins
  output logic [2:0]      capture_in
);
  initial capture_in = 3'h0;
  // a pin keeps its level until told otherwise, as a real source does
  task automatic set(input logic [2:0] v);
    @(posedge aclk);
    capture_in <= v;
  endtask
endmodule

/* testbench/three_channel_input_capture_ctrl_tb.sv */
// Purpose: register-level tests of edge capture, filter, flags and interrupt
// Assumes: registers reset to zero; flags settle within 12 cycles, 16 filtered
// Notes:   edge select is never given the reserved value
`timescale 1ns/1ps
module three_channel_input_capture_ctrl_tb;
  import capture_ctrl_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, capture_irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  capture_in;
  int          n_fail, n_compared, cyc;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch %0t value differs", $time); end end
  three_channel_input_capture_ctrl dut (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .capture_in    (capture_in),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .capture_irq   (capture_irq)
  );
  capture_pins_model pins (.aclk(aclk), .capture_in(capture_in));
  function automatic logic [11:0] A(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  task automatic wr(input logic [7:0] i, input logic [7:0] v, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= A(i); s_axi_wdata <= {24'h00_0000, v};
    // ready waits for the response, so a stalled response is exercised too
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1));
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, e)
  endtask
  task automatic rd(input logic [7:0] i);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1; s_axi_araddr <= A(i);
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1));
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      wrap_up;
    end
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    s_axi_awaddr = 0; s_axi_araddr = 0; s_axi_wdata = 0; s_axi_wstrb = 4'hF;
    idle(5);
    aresetn <= 1'b1;
    for (int k = 0; k < 5; k++)
    begin
      rd(k < 3 ? 8'h92 + 8'(k) : 8'h98 + 8'(k - 3));
      `CHK({d, r}, {32'h0000_0000, resp_okay})
    end
    rd(8'h95);
    `CHK({d, r}, {read_zero, resp_slverr})
    wr(8'h95, 8'hFF, resp_slverr);
    for (int c = 0; c < 3; c++)
      for (int m = 0; m < 3; m++)
      begin
        wr(edge_select_index, 8'(m) << (2 * c), resp_okay);
        wr(enable_flags_index, 8'h10 << c, resp_okay);
        pins.set(3'h1 << c);
        idle(12);
        rd(enable_flags_index);
        `CHK(d[7:0], (8'h10 << c) | ((m != 0) ? (8'h01 << c) : 8'h00))
        wr(enable_flags_index, 8'h10 << c, resp_okay);
        pins.set(3'h0);
        idle(12);
        rd(enable_flags_index);
        `CHK(d[7:0], (8'h10 << c) | ((m != 1) ? (8'h01 << c) : 8'h00))
      end
    wr(enable_flags_index, 8'h00, resp_okay);
    pins.set(3'h7);
    idle(4);
    pins.set(3'h0);
    idle(12);
    rd(enable_flags_index);
    `CHK(d[7:0], 8'h00)
    wr(edge_select_index, 8'h2A, resp_okay);
    wr(filter_index, 8'h60, resp_okay);
    wr(enable_flags_index, 8'h70, resp_okay);
    pins.set(3'h7);
    idle(1);
    pins.set(3'h0);
    idle(16);
    rd(enable_flags_index);
    `CHK(d[7:0], 8'h71)
    pins.set(3'h7);
    idle(16);
    rd(enable_flags_index);
    `CHK(d[7:0], 8'h77)
    // a write without its low byte strobe must leave flags and enables alone
    s_axi_wstrb <= 4'hE;
    wr(enable_flags_index, 8'h00, resp_okay);
    s_axi_wstrb <= 4'hF;
    rd(enable_flags_index);
    `CHK(d[7:0], 8'h77)
    rd(irq_status_index);
    `CHK(d[7:0], 8'h07)
    wr(irq_mask_index, 8'h00, resp_okay);
    pins.set(3'h0);
    idle(16);
    `CHK(capture_irq, 1'b0)
    wr(irq_mask_index, 8'h01, resp_okay);
    `CHK(capture_irq, 1'b1)
    rd(irq_status_index);
    `CHK(d[7:0], 8'h07)
    idle(1);
    `CHK(capture_irq, 1'b0)
    wrap_up;
  end
endmodule
